/* File: hdl/bst_tap.sv */
// Boundary-scan test access port: TAP controller, instruction and data registers.
// Assumes the test clock is much slower than MCLK; it is sampled and its edges found.
`timescale 1ns/10ps
// Operation
// - Standard TAP states, instruction and data registers
// - Mode select and data in taken on rise
// - Data out changes on test clock fall
// - Port active only while test select asserted
// - All-zeros and all-ones codes select bypass
// - FFF8 samples pins, normal operation kept
// - FFE8 drives pins from scan register
// - FFEF holds outputs, bypass shifts
// - FFFE selects fixed 32-bit identification
// - FFCF disables drivers, bypass shifts
// - Every digital pin has a scan cell
module bst_tap
    import bst_pkg::*;
(
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic TEST_SEL,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    output logic TDO,
    output logic TDO_OE,
    input wire logic [BST_NPIN-1:0] CORE_OUT,
    input wire logic [BST_NPIN-1:0] CORE_OE,
    output logic [BST_NPIN-1:0] CORE_IN,
    input wire logic [BST_NPIN-1:0] PIN_IN,
    output logic [BST_NPIN-1:0] PIN_OUT,
    output logic [BST_NPIN-1:0] PIN_OE
);
    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    logic tck_rise;
    logic tck_fall;
    logic tms_q;
    logic tdi_q;
    logic sel_q;
    logic [BST_NPIN-1:0] pin_s1_r;
    logic [BST_NPIN-1:0] pin_q_r;

    bst_sync u_tck (.clk(MCLK), .rst(SYS_RST), .d(TCK), .q(), .rise(tck_rise),
        .fall(tck_fall));
    bst_sync u_tms (.clk(MCLK), .rst(SYS_RST), .d(TMS), .q(tms_q), .rise(), .fall());
    bst_sync u_tdi (.clk(MCLK), .rst(SYS_RST), .d(TDI), .q(tdi_q), .rise(), .fall());
    bst_sync u_sel (.clk(MCLK), .rst(SYS_RST), .d(TEST_SEL), .q(sel_q), .rise(), .fall());

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_s1_r <= '0;
            pin_q_r <= '0;
        end else begin
            pin_s1_r <= PIN_IN;
            pin_q_r <= pin_s1_r;
        end
    end

    // Sampling delays TCK, TMS, TDI and TEST_SEL equally, so TMS and TDI stay aligned to the edge
    logic rise_en;
    logic fall_en;
    assign rise_en = tck_rise & sel_q;
    assign fall_en = tck_fall & sel_q;

    // ------------------------------------------------------------
    // TAP state machine
    // ------------------------------------------------------------
    bst_state_t state_r;
    bst_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BST_S_RESET: state_nxt = tms_q ? BST_S_RESET : BST_S_IDLE;
            BST_S_IDLE: state_nxt = tms_q ? BST_S_SEL_DR : BST_S_IDLE;
            BST_S_SEL_DR: state_nxt = tms_q ? BST_S_SEL_IR : BST_S_CAP_DR;
            BST_S_CAP_DR: state_nxt = tms_q ? BST_S_EX1_DR : BST_S_SH_DR;
            BST_S_SH_DR: state_nxt = tms_q ? BST_S_EX1_DR : BST_S_SH_DR;
            BST_S_EX1_DR: state_nxt = tms_q ? BST_S_UPD_DR : BST_S_PAU_DR;
            BST_S_PAU_DR: state_nxt = tms_q ? BST_S_EX2_DR : BST_S_PAU_DR;
            BST_S_EX2_DR: state_nxt = tms_q ? BST_S_UPD_DR : BST_S_SH_DR;
            BST_S_UPD_DR: state_nxt = tms_q ? BST_S_SEL_DR : BST_S_IDLE;
            BST_S_SEL_IR: state_nxt = tms_q ? BST_S_RESET : BST_S_CAP_IR;
            BST_S_CAP_IR: state_nxt = tms_q ? BST_S_EX1_IR : BST_S_SH_IR;
            BST_S_SH_IR: state_nxt = tms_q ? BST_S_EX1_IR : BST_S_SH_IR;
            BST_S_EX1_IR: state_nxt = tms_q ? BST_S_UPD_IR : BST_S_PAU_IR;
            BST_S_PAU_IR: state_nxt = tms_q ? BST_S_EX2_IR : BST_S_PAU_IR;
            BST_S_EX2_IR: state_nxt = tms_q ? BST_S_UPD_IR : BST_S_SH_IR;
            BST_S_UPD_IR: state_nxt = tms_q ? BST_S_SEL_DR : BST_S_IDLE;
            default: state_nxt = BST_S_RESET;
        endcase
    end

    // Leaving test mode returns the controller to reset
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= BST_S_RESET;
        end else if (!sel_q) begin
            state_r <= BST_S_RESET;
        end else if (rise_en) begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------
    function automatic bst_instr_t bst_decode(input logic [BST_IR_W-1:0] op);
        unique case (op)
            BST_OP_SAMPLE: bst_decode = BST_I_SAMPLE;
            BST_OP_EXTEST: bst_decode = BST_I_EXTEST;
            BST_OP_IDCODE: bst_decode = BST_I_IDCODE;
            BST_OP_CLAMP, BST_OP_HIGHZ: bst_decode = BST_I_CLAMP;
            default: bst_decode = BST_I_BYPASS;
        endcase
    endfunction : bst_decode

    logic [BST_IR_W-1:0] ir_sh_r;
    logic [BST_IR_W-1:0] ir_r;
    bst_instr_t instr;
    logic highz;
    assign instr = bst_decode(ir_r);
    assign highz = (ir_r == BST_OP_HIGHZ);

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ir_sh_r <= BST_IR_CAPTURE;
        end else if (rise_en) begin
            if (state_r == BST_S_CAP_IR) begin
                ir_sh_r <= BST_IR_CAPTURE;
            end else if (state_r == BST_S_SH_IR) begin
                ir_sh_r <= {tdi_q, ir_sh_r[BST_IR_W-1:1]};
            end
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ir_r <= BST_IR_RESET;
        end else if (!sel_q || state_r == BST_S_RESET) begin
            ir_r <= BST_IR_RESET;
        end else if (fall_en && state_r == BST_S_UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // ------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------
    // Cell order per pin: input, output, enable; the chain covers every digital pin
    logic byp_r;
    logic [BST_ID_W-1:0] id_r;
    logic [BST_BSR_W-1:0] bsr_sh_r;
    logic [BST_BSR_W-1:0] bsr_upd_r;
    logic [BST_BSR_W-1:0] bsr_cap;

    always_comb begin
        bsr_cap = '0;
        for (int i = 0; i < BST_NPIN; i++) begin
            bsr_cap[3*i] = pin_q_r[i];
            bsr_cap[3*i+1] = CORE_OUT[i];
            bsr_cap[3*i+2] = CORE_OE[i];
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            byp_r <= 1'b0;
            id_r <= '0;
            bsr_sh_r <= '0;
        end else if (rise_en) begin
            if (state_r == BST_S_CAP_DR) begin
                byp_r <= 1'b0;
                id_r <= BST_ID_VALUE;
                if (instr == BST_I_SAMPLE || instr == BST_I_EXTEST) begin
                    bsr_sh_r <= bsr_cap;
                end
            end else if (state_r == BST_S_SH_DR) begin
                unique case (instr)
                    BST_I_IDCODE: id_r <= {tdi_q, id_r[BST_ID_W-1:1]};
                    BST_I_SAMPLE, BST_I_EXTEST: begin
                        bsr_sh_r <= {tdi_q, bsr_sh_r[BST_BSR_W-1:1]};
                    end
                    default: byp_r <= tdi_q;
                endcase
            end
        end
    end

    // Update register keeps preloaded values across instruction changes
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bsr_upd_r <= '0;
        end else if (fall_en && state_r == BST_S_UPD_DR &&
                     (instr == BST_I_SAMPLE || instr == BST_I_EXTEST)) begin
            bsr_upd_r <= bsr_sh_r;
        end
    end

    // ------------------------------------------------------------
    // Pin multiplexing
    // ------------------------------------------------------------
    logic drive_bsr;
    assign drive_bsr = sel_q && (instr == BST_I_EXTEST || instr == BST_I_CLAMP);

    always_comb begin
        for (int i = 0; i < BST_NPIN; i++) begin
            PIN_OUT[i] = drive_bsr ? bsr_upd_r[3*i+1] : CORE_OUT[i];
            PIN_OE[i] = drive_bsr ? bsr_upd_r[3*i+2] : CORE_OE[i];
            if (sel_q && highz) begin
                PIN_OE[i] = 1'b0;
            end
        end
    end
    // Core sees the pads except under extest, where it sees the update cells
    always_comb begin
        for (int i = 0; i < BST_NPIN; i++) begin
            CORE_IN[i] = (sel_q && instr == BST_I_EXTEST) ? bsr_upd_r[3*i] : pin_q_r[i];
        end
    end

    // ------------------------------------------------------------
    // Test data output
    // ------------------------------------------------------------
    logic tdo_r;
    logic tdo_oe_r;
    logic tdo_nxt;

    always_comb begin
        tdo_nxt = byp_r;
        if (state_r == BST_S_SH_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (instr == BST_I_IDCODE) begin
            tdo_nxt = id_r[0];
        end else if (instr == BST_I_SAMPLE || instr == BST_I_EXTEST) begin
            tdo_nxt = bsr_sh_r[0];
        end
    end

    // Output is registered on the falling edge so the tester samples a settled bit
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (!sel_q) begin
            tdo_oe_r <= 1'b0;
        end else if (fall_en) begin
            tdo_r <= tdo_nxt;
            tdo_oe_r <= (state_r == BST_S_SH_DR) || (state_r == BST_S_SH_IR);
        end
    end
    assign TDO = tdo_r;
    assign TDO_OE = tdo_oe_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Edge strobes last one cycle, so the reset check counts TMS ones instead
    logic [2:0] ones_r;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ones_r <= 3'h0;
        end else if (rise_en) begin
            if (!tms_q) begin
                ones_r <= 3'h0;
            end else if (ones_r != 3'h4) begin
                ones_r <= ones_r + 3'h1;
            end
        end
    end

    AST_TDO_FALL: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !$past(fall_en) |-> $stable(TDO))
        else $error("TDO changed away from a test clock fall");
    AST_STATE_RISE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        ($changed(state_r) && sel_q && $past(sel_q)) |-> $past(rise_en))
        else $error("TAP state moved without a test clock rise");
    AST_SEL_OFF: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !sel_q |=> (state_r == BST_S_RESET) && !TDO_OE)
        else $error("Test port active without test select");
    AST_TLR_RESET: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (rise_en && tms_q && ones_r == 3'h4) |=> state_r == BST_S_RESET)
        else $error("Five TMS ones did not reach reset");
    AST_BYPASS: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (ir_r == BST_OP_BYPASS0 || ir_r == BST_OP_BYPASS1) |-> instr == BST_I_BYPASS)
        else $error("Bypass code not decoded as bypass");
    AST_SAMPLE_PINS: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (instr == BST_I_SAMPLE) |-> (PIN_OUT == CORE_OUT && PIN_OE == CORE_OE))
        else $error("Sample disturbed pin operation");
    AST_EXTEST_DRIVE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (sel_q && instr == BST_I_EXTEST) |-> PIN_OUT[0] == bsr_upd_r[1])
        else $error("Extest not driving from scan register");
    AST_CLAMP_HOLD: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (sel_q && ir_r == BST_OP_CLAMP && rise_en && state_r == BST_S_SH_DR)
        |=> byp_r == $past(tdi_q) && $stable(PIN_OUT))
        else $error("Clamp did not shift bypass or hold pins");
    AST_IDCODE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (rise_en && state_r == BST_S_CAP_DR && instr == BST_I_IDCODE) |=> id_r == BST_ID_VALUE)
        else $error("Identification value not captured");
    AST_HIGHZ: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (sel_q && ir_r == BST_OP_HIGHZ) |-> PIN_OE == '0)
        else $error("Drivers enabled under high impedance");
    AST_UNKNOWN: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (ir_r == 16'h1234) |-> instr == BST_I_BYPASS)
        else $error("Unknown code not treated as bypass");
    AST_CELL_CAP: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (rise_en && state_r == BST_S_CAP_DR && instr == BST_I_SAMPLE)
        |=> bsr_sh_r[0] == $past(pin_q_r[0]))
        else $error("Pin cell not captured");
endmodule : bst_tap

/* File: hdl/bst_pkg.sv */
// Package for the boundary-scan test port: opcodes, sizes, reset values.
// Assumes a single system clock; the test clock arrives as an ordinary sampled input.
package bst_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int BST_IR_W = 16;
    localparam int BST_ID_W = 32;
    localparam int BST_NPIN = 8;
    localparam int BST_BSR_W = 3 * BST_NPIN;
    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [15:0] BST_OP_BYPASS0 = 16'h0000;
    localparam logic [15:0] BST_OP_BYPASS1 = 16'hFFFF;
    localparam logic [15:0] BST_OP_SAMPLE = 16'hFFF8;
    localparam logic [15:0] BST_OP_EXTEST = 16'hFFE8;
    localparam logic [15:0] BST_OP_CLAMP = 16'hFFEF;
    localparam logic [15:0] BST_OP_IDCODE = 16'hFFFE;
    localparam logic [15:0] BST_OP_HIGHZ = 16'hFFCF;
    // ------------------------------------------------------------
    // Reset and capture values
    // ------------------------------------------------------------
    localparam logic [15:0] BST_IR_RESET = 16'hFFFE;
    localparam logic [15:0] BST_IR_CAPTURE = 16'h0001;
    // Identification value is arbitrary, bit 0 must be one
    localparam logic [31:0] BST_ID_VALUE = 32'h0ABC_D001;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [15:0] {
        BST_S_RESET = 16'h0001,
        BST_S_IDLE = 16'h0002,
        BST_S_SEL_DR = 16'h0004,
        BST_S_CAP_DR = 16'h0008,
        BST_S_SH_DR = 16'h0010,
        BST_S_EX1_DR = 16'h0020,
        BST_S_PAU_DR = 16'h0040,
        BST_S_EX2_DR = 16'h0080,
        BST_S_UPD_DR = 16'h0100,
        BST_S_SEL_IR = 16'h0200,
        BST_S_CAP_IR = 16'h0400,
        BST_S_SH_IR = 16'h0800,
        BST_S_EX1_IR = 16'h1000,
        BST_S_PAU_IR = 16'h2000,
        BST_S_EX2_IR = 16'h4000,
        BST_S_UPD_IR = 16'h8000
    } bst_state_t;
    typedef enum logic [4:0] {
        BST_I_BYPASS = 5'h01,
        BST_I_SAMPLE = 5'h02,
        BST_I_EXTEST = 5'h04,
        BST_I_IDCODE = 5'h08,
        BST_I_CLAMP = 5'h10
    } bst_instr_t;
endpackage : bst_pkg

/* File: hdl/bst_sync.sv */
// Two-flop synchroniser with edge detection on the second stage output.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module bst_sync
    import bst_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // First stage is read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign q = s2_r;
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule : bst_sync

/* File: tb/bst_ctl.sv */
// Model of the external test controller that drives the scan port.
// Assumes the caller waits for reset and test select before the first task call.
`timescale 1ns/10ps
module bst_ctl (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Unused data line toggles so a stale level is never mistaken for data
    logic junk_r = 1'b0;
    int unstable = 0;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // ------------------------------------------------------------
    // One test clock period; the clock stays low between frames
    // ------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        tck = 1'b1;
        q = tdo;
        #60;
        if (tdo !== q) unstable++;
        #2.5;
        tck = 1'b0;
    endtask : step
    task automatic nav(input logic m);
        logic q;
        step(m, junk_r, q);
        junk_r = ~junk_r;
    endtask : nav
    task automatic reset_tap();
        repeat (5) nav(1'b1);
        nav(1'b0);
    endtask : reset_tap
    // Shift n bits LSB first, then Update and back to Idle
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        nav(1'b1);
        nav(1'b0);
    endtask : shift
    task automatic load_ir(input logic [15:0] code, output logic [31:0] cap);
        nav(1'b1);
        nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        shift(16, {16'h0000, code}, cap);
    endtask : load_ir
    task automatic scan_dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        nav(1'b1);
        nav(1'b0);
        nav(1'b0);
        shift(n, din, dout);
    endtask : scan_dr
endmodule : bst_ctl

/* File: tb/bst_tap_bench.sv */
// Self-checking bench for the scan port, with the controller model on its far side.
// Assumes the design package and the controller model are compiled first.
`timescale 1ns/10ps
module bst_tap_bench
    import bst_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic test_sel = 1'b0;
    logic [BST_NPIN-1:0] core_out = 8'h00;
    logic [BST_NPIN-1:0] core_oe = 8'h00;
    logic [BST_NPIN-1:0] pin_in = 8'h00;
    logic tck, tms, tdi, tdo, tdo_oe;
    // Pull-up on the data out line: a released driver reads as one
    logic tdo_pad;
    assign tdo_pad = tdo_oe ? tdo : 1'b1;
    logic [BST_NPIN-1:0] core_in, pin_out, pin_oe;
    logic [31:0] preload = 32'h00C3_5A96;
    int miscompares = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    bst_tap i_bst_tap (.MCLK(mclk), .SYS_RST(sys_rst), .TEST_SEL(test_sel), .TCK(tck),
        .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .CORE_OUT(core_out),
        .CORE_OE(core_oe), .CORE_IN(core_in), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE(pin_oe));
    bst_ctl i_bst_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pad));
    // ------------------------------------------------------------
    // Compare, closing and pin-setting tasks
    // ------------------------------------------------------------
    task automatic chk_scan(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_scan
    task automatic chk_pins(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_pins
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task automatic set_pins(input logic [7:0] o, input logic [7:0] e, input logic [7:0] p);
        @(posedge mclk);
        core_out <= o;
        core_oe <= e;
        pin_in <= p;
        repeat (6) @(posedge mclk);
    endtask : set_pins
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_id();
        logic [31:0] d;
        chk_scan({31'h0, tdo_oe}, 32'h0, "data out enable idle");
        i_bst_ctl.reset_tap();
        i_bst_ctl.scan_dr(32, 32'h0, d);
        chk_scan(d, BST_ID_VALUE, "identification after reset");
        $display("test reset_id done");
    endtask : t_reset_id
    task automatic t_sample();
        logic [31:0] d, e;
        i_bst_ctl.load_ir(BST_OP_SAMPLE, d);
        chk_scan(d, 32'h1, "ir capture");
        e = '0;
        for (int i = 0; i < BST_NPIN; i++) e[3*i +: 3] = {core_oe[i], core_out[i], pin_in[i]};
        i_bst_ctl.scan_dr(BST_BSR_W, preload, d);
        chk_scan(d, e, "sample capture of every pin");
        chk_pins(pin_out, core_out, "sample keeps outputs");
        chk_pins(pin_oe, core_oe, "sample keeps enables");
        $display("test sample done");
    endtask : t_sample
    task automatic t_extest();
        logic [31:0] d, m, e;
        logic [7:0] eo, ee, ei;
        for (int i = 0; i < BST_NPIN; i++) {ee[i], eo[i], ei[i]} = preload[3*i +: 3];
        i_bst_ctl.load_ir(BST_OP_EXTEST, d);
        chk_pins(pin_out, eo, "extest outputs");
        chk_pins(pin_oe, ee, "extest enables");
        chk_pins(core_in, ei, "extest core inputs");
        set_pins(8'h0F, 8'hF0, 8'hC3);
        m = 32'h0;
        e = 32'h0;
        for (int i = 0; i < BST_NPIN; i++) begin
            m[3*i] = 1'b1;
            e[3*i] = pin_in[i];
        end
        i_bst_ctl.scan_dr(BST_BSR_W, preload, d);
        chk_scan(d & m, e, "extest input capture");
        $display("test extest done");
    endtask : t_extest
    task automatic t_bypass_codes();
        logic [15:0] codes [5] = '{BST_OP_BYPASS0, BST_OP_BYPASS1, 16'h1234, BST_OP_CLAMP,
            BST_OP_HIGHZ};
        logic [31:0] d;
        logic [7:0] eo;
        for (int i = 0; i < BST_NPIN; i++) eo[i] = preload[3*i+1];
        foreach (codes[k]) begin
            i_bst_ctl.load_ir(codes[k], d);
            chk_scan(d, 32'h1, "ir capture");
            i_bst_ctl.scan_dr(8, 32'hB6, d);
            chk_scan(d, 32'h6C, "one bit bypass path");
            if (codes[k] == BST_OP_CLAMP) chk_pins(pin_out, eo, "clamp holds");
            if (codes[k] == BST_OP_HIGHZ) chk_pins(pin_oe, 8'h00, "drivers off");
        end
        $display("test bypass_codes done");
    endtask : t_bypass_codes
    task automatic t_test_sel_off();
        logic [31:0] d;
        @(posedge mclk);
        test_sel <= 1'b0;
        set_pins(8'h96, 8'h69, 8'h3A);
        chk_pins(pin_out, core_out, "normal outputs");
        chk_pins(pin_oe, core_oe, "normal enables");
        chk_pins(core_in, pin_in, "normal inputs");
        // Edges while deselected must be ignored; the released line reads as ones
        i_bst_ctl.load_ir(BST_OP_BYPASS0, d);
        chk_scan(d, 32'h0000_FFFF, "scan ignored when deselected");
        chk_scan({31'h0, tdo_oe}, 32'h0, "no drive when deselected");
        @(posedge mclk);
        test_sel <= 1'b1;
        repeat (4) @(posedge mclk);
        i_bst_ctl.nav(1'b0);
        i_bst_ctl.scan_dr(32, 32'h0, d);
        chk_scan(d, BST_ID_VALUE, "identification after deselect");
        $display("test test_sel_off done");
    endtask : t_test_sel_off
    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        test_sel <= 1'b1;
        set_pins(8'hA5, 8'h3C, 8'h5A);
        t_reset_id();
        t_sample();
        t_extest();
        t_bypass_codes();
        t_test_sel_off();
        chk_scan(i_bst_ctl.unstable, 32'h0, "data out moved while clock high");
        complete_run();
    end
    // About 400 test clock periods are expected; allow eight times that
    initial begin
        #400000;
        miscompares++;
        $display("ERROR t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule : bst_tap_bench
